// >>> tb/pll_sync_phase_register_bank_tb.sv
`timescale 1ns/1ps
module pll_sync_phase_register_bank_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sync_pin = 1'b0;
    logic ref_tick = 1'b0;
    logic pfd_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic rd_flag = 1'b0;
    logic reg_wr_en, reg_rd_en, bleed_on, bleed_direction, software_sync_request, retimed_sync_select;
    logic ref_divider_reset, resync_mode_on, resync_busy, resync_apply, apply_phase_shift;
    logic vco_calibration_on, reference_doubler_on, vco_cal_start;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, phase_shift_amount;
    logic [23:0] aux_modulus_value, phase_value, resync_delay_count;
    logic [12:0] bleed_current;
    logic [3:0] pump_current_code;
    logic [5:0] ref_divider_ratio;
    int mismatches = 0;
    int checks = 0;

    pllsp_host host (.clock, .wr_en(reg_wr_en), .rd_en(reg_rd_en), .addr(reg_addr), .wdata(reg_wr_data));

    pllsp_bank uut (.clock, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .sync_pin, .ref_tick, .pfd_tick, .aux_modulus_value, .bleed_current, .bleed_on, .bleed_direction,
        .pump_current_code, .software_sync_request, .retimed_sync_select, .ref_divider_reset,
        .resync_mode_on, .resync_busy, .resync_apply, .apply_phase_shift, .phase_shift_amount,
        .phase_value, .resync_delay_count, .vco_calibration_on, .reference_doubler_on,
        .ref_divider_ratio, .vco_cal_start);

    always #5 clock = ~clock;

    // phase detector strobe every fourth cycle
    always @(posedge clock) begin
        tick_cnt <= tick_cnt + 2'h1;
        pfd_tick <= (tick_cnt == 2'h3);
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [23:0] word(input int k);
        return (k == 0) ? aux_modulus_value : (k == 1) ? phase_value : resync_delay_count;
    endfunction

    // read data lands one cycle after the strobe; compare with oldest note
    always @(posedge clock) rd_flag <= reg_rd_en;
    always @(negedge clock) begin
        if (rd_flag === 1'b1) chk(reg_rd_data, host.exp_q.pop_front());
    end

    // watchdog
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] a;
        logic [7:0] w [3];
        int n;
        int cnt;
        int t;
        void'($urandom(14638));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        // reset values, then an unmapped byte
        for (int i = 0; i < 14; i++) host.rd(8'h1A + 8'(i), (i == 6) ? 8'h01 : 8'h00);
        host.wr(8'h30, 8'hFF);
        host.rd(8'h30, 8'h00);
        chk(ref_divider_ratio, 24'h1);
        // multi-byte words move only when the top byte lands
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3; j++) w[j] = 8'($urandom);
            a = (k == 0) ? 8'h1A : (k == 1) ? 8'h21 : 8'h25;
            host.wr(a, w[0]);
            host.wr(a + 8'h1, w[1]);
            @(negedge clock);
            chk(word(k), 24'h0);
            host.wr(a + 8'h2, w[2]);
            @(negedge clock);
            chk(word(k), {w[2], w[1], w[0]});
            host.rd(a + 8'h1, w[1]);
        end
        // bleed word commits with its high byte
        w[0] = 8'($urandom);
        d = 8'($urandom) & 8'h3F;
        host.wr(8'h1D, w[0]);
        @(negedge clock);
        chk(bleed_current, 24'h0);
        host.wr(8'h1E, d);
        @(negedge clock);
        chk(bleed_current, {d[4:0], w[0]});
        chk(retimed_sync_select, d[5]);
        chk(resync_mode_on, 1'b0);
        // every pump code with random bleed bits
        for (int i = 0; i < 16; i++) begin
            d = {2'b00, 2'($urandom), 4'(i)};
            host.wr(8'h1F, d);
            @(negedge clock);
            chk({bleed_direction, bleed_on, pump_current_code}, d[5:0]);
            chk(apply_phase_shift, 1'b0);
        end
        // phase shift amount and its one-cycle apply pulse
        d = 8'($urandom);
        host.wr(8'h24, d);
        host.wr(8'h1F, 8'h40);
        @(negedge clock);
        chk(phase_shift_amount, d);
        chk(apply_phase_shift, 1'b1);
        @(negedge clock);
        chk(apply_phase_shift, 1'b0);
        host.rd(8'h1F, 8'h40);
        // divider fields, calibration trigger only while enabled
        for (int i = 0; i < 2; i++) begin
            d = {i[0], 7'($urandom)};
            host.wr(8'h20, d);
            @(negedge clock);
            chk({vco_calibration_on, reference_doubler_on, ref_divider_ratio}, d);
            host.wr(8'h10, 8'($urandom));
            @(negedge clock);
            chk(vco_cal_start, d[7]);
            chk(resync_busy, 1'b0);
        end
        // software and pin sync, direct then retimed
        host.wr(8'h1E, 8'h40);
        host.wr(8'h1F, 8'h80);
        repeat (2) @(negedge clock);
        chk(ref_divider_reset, 1'b1);
        chk(software_sync_request, 1'b1);
        host.wr(8'h1F, 8'h00);
        repeat (2) @(negedge clock);
        chk(ref_divider_reset, 1'b0);
        @(posedge clock);
        sync_pin <= 1'b1;
        repeat (2) @(negedge clock);
        chk(ref_divider_reset, 1'b1);
        @(posedge clock);
        sync_pin <= 1'b0;
        host.wr(8'h1E, 8'h60);
        @(posedge clock);
        sync_pin <= 1'b1;
        repeat (4) @(negedge clock);
        chk(ref_divider_reset, 1'b0);
        @(posedge clock);
        ref_tick <= 1'b1;
        @(posedge clock);
        ref_tick <= 1'b0;
        repeat (2) @(negedge clock);
        chk(ref_divider_reset, 1'b1);
        @(posedge clock);
        sync_pin <= 1'b0;
        // resync waits the programmed count of detector periods
        n = 1 + ($urandom % 6);
        host.wr(8'h25, 8'(n));
        host.wr(8'h26, 8'h00);
        host.wr(8'h27, 8'h00);
        host.wr(8'h1E, 8'h80);
        host.wr(8'h10, 8'h00);
        @(negedge clock);
        chk(resync_busy, 1'b1);
        cnt = 0;
        t = 0;
        while (resync_apply !== 1'b1 && t < 200) begin
            if (pfd_tick === 1'b1) cnt++;
            t++;
            @(negedge clock);
        end
        chk(24'(cnt), 24'(n));
        chk(resync_busy, 1'b0);
        repeat (3) @(negedge clock);
        stop_test();
    end
endmodule

// >>> tb/pllsp_host.sv
`timescale 1ns/1ps
// host side of the register port, one access per call
module pllsp_host (
    input wire logic clock,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    logic [7:0] exp_q [$];

    // idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // write one byte; idle bus shows inverted junk, not the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // read one byte and note the value it should return
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
    endtask
endmodule

// >>> verilog/pllsp_bank.sv
// Contract
// RL1: 24-bit auxiliary modulus in three byte registers, low byte first, reset zero.
// RL2: 13-bit bleed current, low eight bits then bits 4..0; 4 coarse, 9 fine.
// RL3: bleed enable bit 4 turns bleed on; direction bit 5 selects source when 1.
// RL4: 4-bit charge pump current code in sync control bits 3..0.
// RL5: with reference reset enabled, software sync or pin resets the reference divider.
// RL6: retime clear resets divider directly; retime set aligns sync to reference clock.
// RL7: phase resync mode enable in bleed-high bit 7, off at reset.
// RL8: in resync mode, after integer word write wait count times PFD period, then resync.
// RL9: writing 1 to phase adjust bit 6 applies the programmed phase shift.
// RL10: 8-bit phase shift amount, degrees times 4096 over 360.
// RL11: 24-bit phase value in three byte registers, low byte first, reset zero.
// RL12: divider bit 7 enables VCO calibration, bit 6 enables reference doubler.
// RL13: 6-bit reference divider in bits 5..0, register resets to one, others zero.
// RL14: integer word write at 0x10 starts calibration only while calibration enabled.
// RL15: resync_delay_count count is 24 bits, upper byte after the middle byte.
// RL16: multi-byte values reach the datapath only when complete.
`timescale 1ns/1ps
`include "pllsp_map.svh"
module pllsp_bank
    import pllsp_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic sync_pin,
    input wire logic ref_tick,
    input wire logic pfd_tick,
    output logic [23:0] aux_modulus_value,
    output logic [12:0] bleed_current,
    output logic bleed_on,
    output logic bleed_direction,
    output logic [3:0] pump_current_code,
    output logic software_sync_request,
    output logic retimed_sync_select,
    output logic ref_divider_reset,
    output logic resync_mode_on,
    output logic resync_busy,
    output logic resync_apply,
    output logic apply_phase_shift,
    output logic [7:0] phase_shift_amount,
    output logic [23:0] phase_value,
    output logic [23:0] resync_delay_count,
    output logic vco_calibration_on,
    output logic reference_doubler_on,
    output logic [5:0] ref_divider_ratio,
    output logic vco_cal_start
);
    logic nrst_meta_reg;
    logic rst_n;
    pllsp_byte_t regs_reg [`PLLSP_NREGS];
    logic [7:0] offset;
    logic [3:0] idx;
    logic in_range;
    logic wr_hit;
    logic int_word_wr;
    pllsp_byte_t rd_data_reg;
    pllsp_word24_t aux_reg;
    pllsp_word24_t phase_reg;
    pllsp_word24_t wait_reg;
    logic [12:0] bleed_reg;
    logic shift_pulse_reg;
    logic cal_start_reg;

    pllsp_ctl_if ctl ();

    // reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nrst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            nrst_meta_reg <= 1'b1;
            rst_n <= nrst_meta_reg;
        end
    end

    // address decode of the byte register slice
    assign offset = reg_addr - `PLLSP_ADDR_BASE;
    assign in_range = (reg_addr >= `PLLSP_ADDR_AUX_LO) && (reg_addr <= `PLLSP_ADDR_WAIT_HI);
    assign idx = offset[3:0];
    assign wr_hit = reg_wr_en && in_range;
    assign int_word_wr = reg_wr_en && (reg_addr == `PLLSP_ADDR_INT_WORD);

    // byte register file; divider control resets to one, the rest to zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PLLSP_NREGS; i++) begin
                if (i == int'(`PLLSP_IDX_DIV_CTL)) begin
                    regs_reg[i] <= `PLLSP_RST_DIV_CTL; // [RL13]
                end else begin
                    regs_reg[i] <= `PLLSP_RST_BYTE; // [RL1] [RL11]
                end
            end
        end else if (wr_hit) begin
            regs_reg[idx] <= reg_wr_data;
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= `PLLSP_RST_BYTE;
        end else if (reg_rd_en) begin
            rd_data_reg <= in_range ? regs_reg[idx] : `PLLSP_RST_BYTE;
        end
    end
    assign reg_rd_data = rd_data_reg;

    // auxiliary modulus taken as a whole on the high byte write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aux_reg <= `PLLSP_RST_WORD;
        end else if (wr_hit && idx == `PLLSP_IDX_AUX_HI) begin
            aux_reg <= {reg_wr_data, regs_reg[`PLLSP_IDX_AUX_MID], regs_reg[`PLLSP_IDX_AUX_LO]}; // [RL1] [RL16]
        end
    end

    // bleed current taken as a whole on the high part write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bleed_reg <= `PLLSP_RST_BLEED;
        end else if (wr_hit && idx == `PLLSP_IDX_BLEED_HI) begin
            bleed_reg <= {reg_wr_data[`PLLSP_BLEED_HI_MSB:0], regs_reg[`PLLSP_IDX_BLEED_LO]}; // [RL2] [RL16]
        end
    end

    // phase value taken as a whole on the high byte write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= `PLLSP_RST_WORD;
        end else if (wr_hit && idx == `PLLSP_IDX_PHASE_HI) begin
            phase_reg <= {reg_wr_data, regs_reg[`PLLSP_IDX_PHASE_MID], regs_reg[`PLLSP_IDX_PHASE_LO]}; // [RL11] [RL16]
        end
    end

    // resync_delay_count count taken as a whole on the upper byte write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= `PLLSP_RST_WORD;
        end else if (wr_hit && idx == `PLLSP_IDX_WAIT_HI) begin
            wait_reg <= {reg_wr_data, regs_reg[`PLLSP_IDX_WAIT_MID], regs_reg[`PLLSP_IDX_WAIT_LO]}; // [RL15] [RL16]
        end
    end

    // phase shift strobe on a write with the apply bit set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_pulse_reg <= 1'b0;
        end else begin
            shift_pulse_reg <= wr_hit && (idx == `PLLSP_IDX_SYNC_CTL) && reg_wr_data[`PLLSP_BIT_SHIFT_GO]; // [RL9]
        end
    end

    // calibration start on integer word write while calibration is enabled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cal_start_reg <= 1'b0;
        end else begin
            cal_start_reg <= int_word_wr && regs_reg[`PLLSP_IDX_DIV_CTL][`PLLSP_BIT_CAL_ON]; // [RL14]
        end
    end

    // control fields straight from the byte registers
    assign bleed_on = regs_reg[`PLLSP_IDX_SYNC_CTL][`PLLSP_BIT_BLEED_ON]; // [RL3]
    assign bleed_direction = regs_reg[`PLLSP_IDX_SYNC_CTL][`PLLSP_BIT_BLEED_DIR]; // [RL3]
    assign pump_current_code = regs_reg[`PLLSP_IDX_SYNC_CTL][`PLLSP_PUMP_MSB:0]; // [RL4]
    assign software_sync_request = regs_reg[`PLLSP_IDX_SYNC_CTL][`PLLSP_BIT_SOFT_SYNC]; // [RL5]
    assign retimed_sync_select = regs_reg[`PLLSP_IDX_BLEED_HI][`PLLSP_BIT_RETIME];
    assign resync_mode_on = regs_reg[`PLLSP_IDX_BLEED_HI][`PLLSP_BIT_RESYNC_ON]; // [RL7]
    assign phase_shift_amount = regs_reg[`PLLSP_IDX_SHIFT]; // [RL10]
    assign vco_calibration_on = regs_reg[`PLLSP_IDX_DIV_CTL][`PLLSP_BIT_CAL_ON]; // [RL12]
    assign reference_doubler_on = regs_reg[`PLLSP_IDX_DIV_CTL][`PLLSP_BIT_DOUBLER]; // [RL12]
    assign ref_divider_ratio = regs_reg[`PLLSP_IDX_DIV_CTL][`PLLSP_RDIV_MSB:0]; // [RL13]

    // committed words and strobes
    assign aux_modulus_value = aux_reg;
    assign bleed_current = bleed_reg;
    assign phase_value = phase_reg;
    assign resync_delay_count = wait_reg;
    assign apply_phase_shift = shift_pulse_reg;
    assign vco_cal_start = cal_start_reg;

    // resync timer starts on integer word write in resync mode
    assign ctl.timer_start = int_word_wr && resync_mode_on; // [RL7] [RL8]
    assign ctl.timer_count = wait_reg;
    assign ctl.pfd_tick = pfd_tick;
    assign resync_apply = ctl.timer_done;
    assign resync_busy = ctl.timer_busy;

    // sync path controls
    assign ctl.sync_arm = regs_reg[`PLLSP_IDX_BLEED_HI][`PLLSP_BIT_REF_RST_EN]; // [RL5]
    assign ctl.retime = retimed_sync_select;
    assign ctl.sw_req = software_sync_request;
    assign ctl.pin_req = sync_pin;
    assign ctl.ref_tick = ref_tick;
    assign ref_divider_reset = ctl.div_reset;

    pllsp_wait_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .ctl(ctl.timer)
    );

    pllsp_sync_ctl u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ctl(ctl.syncer)
    );

    sequence s_aux_hi_write;
        wr_hit && idx == `PLLSP_IDX_AUX_HI;
    endsequence

    a_aux_commit: assert property (@(posedge clock) disable iff (!rst_n) // [RL1]
        s_aux_hi_write |=> aux_modulus_value == {$past(reg_wr_data), regs_reg[`PLLSP_IDX_AUX_MID],
                                                  regs_reg[`PLLSP_IDX_AUX_LO]})
        else $error("auxiliary modulus not committed from its bytes");
    a_partial_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RL16]
        (wr_hit && idx != `PLLSP_IDX_AUX_HI) |=> $stable(aux_modulus_value))
        else $error("auxiliary modulus moved on a partial write");
    a_bleed_split: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
        (wr_hit && idx == `PLLSP_IDX_BLEED_HI) |=>
            bleed_current == {regs_reg[`PLLSP_IDX_BLEED_HI][`PLLSP_BLEED_HI_MSB:0], regs_reg[`PLLSP_IDX_BLEED_LO]})
        else $error("bleed current not assembled from its bytes");
    a_bleed_bits: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
        (wr_hit && idx == `PLLSP_IDX_SYNC_CTL) |=>
            bleed_on == $past(reg_wr_data[`PLLSP_BIT_BLEED_ON]) &&
            bleed_direction == $past(reg_wr_data[`PLLSP_BIT_BLEED_DIR]))
        else $error("bleed enable or direction wrong after write");
    a_pump_code: assert property (@(posedge clock) disable iff (!rst_n) // [RL4]
        (wr_hit && idx == `PLLSP_IDX_SYNC_CTL) |=> pump_current_code == $past(reg_wr_data[`PLLSP_PUMP_MSB:0]))
        else $error("pump current code wrong after write");
    a_resync_gate: assert property (@(posedge clock) disable iff (!rst_n) // [RL7]
        (int_word_wr && !resync_busy) |=> resync_busy == $past(resync_mode_on))
        else $error("resync timer started outside resync mode");
    a_shift_pulse: assert property (@(posedge clock) disable iff (!rst_n) // [RL9]
        apply_phase_shift |-> $past(wr_hit && idx == `PLLSP_IDX_SYNC_CTL && reg_wr_data[`PLLSP_BIT_SHIFT_GO]))
        else $error("phase shift applied without a write of the apply bit");
    a_shift_amount: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
        (wr_hit && idx == `PLLSP_IDX_SHIFT) |=> phase_shift_amount == $past(reg_wr_data))
        else $error("phase shift amount not stored");
    a_phase_commit: assert property (@(posedge clock) disable iff (!rst_n) // [RL11]
        (wr_hit && idx == `PLLSP_IDX_PHASE_HI) |=> phase_value[23:16] == $past(reg_wr_data))
        else $error("phase value high byte not committed");
    a_cal_enables: assert property (@(posedge clock) disable iff (!rst_n) // [RL12]
        (wr_hit && idx == `PLLSP_IDX_DIV_CTL) |=>
            vco_calibration_on == $past(reg_wr_data[`PLLSP_BIT_CAL_ON]) &&
            reference_doubler_on == $past(reg_wr_data[`PLLSP_BIT_DOUBLER]))
        else $error("calibration or doubler enable wrong after write");
    a_div_reset_val: assert property (@(posedge clock) disable iff (!nrst) // [RL13]
        $rose(rst_n) |-> ref_divider_ratio == `PLLSP_RST_DIV_CTL && aux_modulus_value == `PLLSP_RST_WORD)
        else $error("reset values wrong");
    a_cal_start: assert property (@(posedge clock) disable iff (!rst_n) // [RL14]
        vco_cal_start == $past(int_word_wr && vco_calibration_on))
        else $error("calibration start does not match integer word write");
    a_wait_commit: assert property (@(posedge clock) disable iff (!rst_n) // [RL15]
        (wr_hit && idx == `PLLSP_IDX_WAIT_HI) |=> resync_delay_count[23:16] == $past(reg_wr_data))
        else $error("resync_delay_count upper byte not committed");
endmodule

// >>> verilog/pllsp_ctl_if.sv
`timescale 1ns/1ps
interface pllsp_ctl_if;
    import pllsp_pkg::*;
    logic timer_start;
    pllsp_word24_t timer_count;
    logic pfd_tick;
    logic timer_done;
    logic timer_busy;
    logic sync_arm;
    logic retime;
    logic sw_req;
    logic pin_req;
    logic ref_tick;
    logic div_reset;
    modport bank (output timer_start, timer_count, pfd_tick, sync_arm, retime, sw_req, pin_req, ref_tick,
                  input timer_done, timer_busy, div_reset);
    modport timer (input timer_start, timer_count, pfd_tick, output timer_done, timer_busy);
    modport syncer (input sync_arm, retime, sw_req, pin_req, ref_tick, output div_reset);
endinterface

// >>> verilog/pllsp_map.svh
`ifndef PLLSP_MAP_SVH
`define PLLSP_MAP_SVH

// register addresses
`define PLLSP_ADDR_INT_WORD 8'h10
`define PLLSP_ADDR_BASE 8'h1A
`define PLLSP_ADDR_AUX_LO 8'h1A
`define PLLSP_ADDR_AUX_MID 8'h1B
`define PLLSP_ADDR_AUX_HI 8'h1C
`define PLLSP_ADDR_BLEED_LO 8'h1D
`define PLLSP_ADDR_BLEED_HI 8'h1E
`define PLLSP_ADDR_SYNC_CTL 8'h1F
`define PLLSP_ADDR_DIV_CTL 8'h20
`define PLLSP_ADDR_PHASE_LO 8'h21
`define PLLSP_ADDR_PHASE_MID 8'h22
`define PLLSP_ADDR_PHASE_HI 8'h23
`define PLLSP_ADDR_SHIFT 8'h24
`define PLLSP_ADDR_WAIT_LO 8'h25
`define PLLSP_ADDR_WAIT_MID 8'h26
`define PLLSP_ADDR_WAIT_HI 8'h27

// register file indices, address minus base
`define PLLSP_NREGS 14
`define PLLSP_IDX_AUX_LO 4'h0
`define PLLSP_IDX_AUX_MID 4'h1
`define PLLSP_IDX_AUX_HI 4'h2
`define PLLSP_IDX_BLEED_LO 4'h3
`define PLLSP_IDX_BLEED_HI 4'h4
`define PLLSP_IDX_SYNC_CTL 4'h5
`define PLLSP_IDX_DIV_CTL 4'h6
`define PLLSP_IDX_PHASE_LO 4'h7
`define PLLSP_IDX_PHASE_MID 4'h8
`define PLLSP_IDX_PHASE_HI 4'h9
`define PLLSP_IDX_SHIFT 4'hA
`define PLLSP_IDX_WAIT_LO 4'hB
`define PLLSP_IDX_WAIT_MID 4'hC
`define PLLSP_IDX_WAIT_HI 4'hD

// reset values
`define PLLSP_RST_DIV_CTL 8'h01
`define PLLSP_RST_BYTE 8'h00
`define PLLSP_RST_WORD 24'h000000
`define PLLSP_RST_BLEED 13'h0000

// bleed-high / sync options fields
`define PLLSP_BIT_RESYNC_ON 7
`define PLLSP_BIT_REF_RST_EN 6
`define PLLSP_BIT_RETIME 5
`define PLLSP_BLEED_HI_MSB 4

// sync control fields
`define PLLSP_BIT_SOFT_SYNC 7
`define PLLSP_BIT_SHIFT_GO 6
`define PLLSP_BIT_BLEED_DIR 5
`define PLLSP_BIT_BLEED_ON 4
`define PLLSP_PUMP_MSB 3

// divider control fields
`define PLLSP_BIT_CAL_ON 7
`define PLLSP_BIT_DOUBLER 6
`define PLLSP_RDIV_MSB 5

`endif

// >>> verilog/pllsp_pkg.sv
package pllsp_pkg;
    // resync_delay_count timer states
    typedef enum logic [0:0] {
        PLLSP_T_IDLE = 1'b0,
        PLLSP_T_WAIT = 1'b1
    } pllsp_tstate_t;
    typedef logic [23:0] pllsp_word24_t;
    typedef logic [7:0] pllsp_byte_t;
endpackage

// >>> verilog/pllsp_sync_ctl.sv
`timescale 1ns/1ps
module pllsp_sync_ctl
    import pllsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    pllsp_ctl_if.syncer ctl
);
    logic req;
    logic div_reset_reg;

    // software request or pin, only when reference reset is enabled
    assign req = ctl.sync_arm && (ctl.sw_req || ctl.pin_req); // [RL5]

    // direct path follows the request; retimed path moves only on a reference edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_reset_reg <= 1'b0;
        end else if (!ctl.retime) begin
            div_reset_reg <= req; // [RL6]
        end else if (ctl.ref_tick) begin
            div_reset_reg <= req; // [RL6]
        end
    end

    assign ctl.div_reset = div_reset_reg;

    sequence s_retimed_req;
        ctl.retime && ctl.ref_tick && req;
    endsequence

    a_sync_direct: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
        !ctl.retime |=> div_reset_reg == $past(req))
        else $error("direct sync did not follow request");
    a_sync_retimed: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
        (ctl.retime && !ctl.ref_tick) |=> $stable(div_reset_reg))
        else $error("retimed sync moved without reference edge");
    a_sync_gate: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
        (!ctl.sync_arm && !ctl.retime) |=> !div_reset_reg)
        else $error("divider reset without reference reset enable");
    a_sync_edge: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
        s_retimed_req |=> div_reset_reg)
        else $error("retimed sync missed on reference edge");
endmodule

// >>> verilog/pllsp_wait_timer.sv
`timescale 1ns/1ps
module pllsp_wait_timer
    import pllsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    pllsp_ctl_if.timer ctl
);
    pllsp_tstate_t state_reg;
    pllsp_word24_t remain_reg;
    pllsp_word24_t cnt_reg;
    pllsp_word24_t seen_reg;
    logic done_reg;
    logic step;

    // one phase detector period elapses while waiting
    assign step = (state_reg == PLLSP_T_WAIT) && !ctl.timer_start && (remain_reg != `PLLSP_RST_WORD) && ctl.pfd_tick;

    // state and countdown; a new start reloads the wait
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PLLSP_T_IDLE;
            remain_reg <= `PLLSP_RST_WORD;
            cnt_reg <= `PLLSP_RST_WORD;
        end else begin
            unique case (state_reg)
                PLLSP_T_IDLE: begin
                    if (ctl.timer_start) begin
                        state_reg <= PLLSP_T_WAIT;
                        remain_reg <= ctl.timer_count;
                        cnt_reg <= ctl.timer_count;
                    end
                end
                PLLSP_T_WAIT: begin
                    if (ctl.timer_start) begin
                        remain_reg <= ctl.timer_count; // [RL8]
                        cnt_reg <= ctl.timer_count;
                    end else if (remain_reg == `PLLSP_RST_WORD) begin
                        state_reg <= PLLSP_T_IDLE;
                    end else if (step) begin
                        remain_reg <= remain_reg - 24'h000001; // [RL8]
                    end
                end
            endcase
        end
    end

    // done pulse when the programmed count of periods has passed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == PLLSP_T_WAIT) && !ctl.timer_start && (remain_reg == `PLLSP_RST_WORD); // [RL8]
        end
    end

    // helper: periods counted since the last start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= `PLLSP_RST_WORD;
        end else if (ctl.timer_start) begin
            seen_reg <= `PLLSP_RST_WORD;
        end else if (step) begin
            seen_reg <= seen_reg + 24'h000001;
        end
    end

    assign ctl.timer_done = done_reg;
    assign ctl.timer_busy = (state_reg == PLLSP_T_WAIT);

    sequence s_wait_started;
        ctl.timer_start ##1 (state_reg == PLLSP_T_WAIT);
    endsequence

    a_resync_fire: assert property (@(posedge clock) disable iff (!rst_n) // [RL8]
        done_reg |-> seen_reg == cnt_reg)
        else $error("resync applied after wrong number of periods");
    a_resync_load: assert property (@(posedge clock) disable iff (!rst_n) // [RL15]
        s_wait_started |-> remain_reg == $past(ctl.timer_count))
        else $error("resync_delay_count count not loaded in full");
endmodule
